// >>> pkg/seq_stack_pkg.sv
// Purpose: shared constants for the sequencer stack entries 28 to 30
// Assumes: each entry is a 16-bit word reached over APB at byte address = 4 * index
// Notes:   field positions, indices and reset words are named once here
package seq_stack_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register indices (printed offsets); byte address is four times these
    localparam int         ENTRY_COUNT  = 3;       // entries held by this bank
    localparam logic [5:0] IDX_ENTRY_28 = 6'h3c;   // sequence_stack_entry_28
    localparam logic [5:0] IDX_ENTRY_29 = 6'h3d;   // sequence_stack_entry_29
    localparam logic [5:0] IDX_ENTRY_30 = 6'h3e;   // sequence_stack_entry_30

    ////////////////////////////////////////////////////////////////////////////
    // reset words
    localparam logic [15:0] RST_ENTRY_28 = 16'h7800;
    localparam logic [15:0] RST_ENTRY_29 = 16'h7a00;
    localparam logic [15:0] RST_ENTRY_30 = 16'h7c00;

    ////////////////////////////////////////////////////////////////////////////
    // field layout of one entry word
    localparam int DIR_BIT  = 15;  // 1 = write frame, 0 = read frame
    localparam int ADDR_MSB = 14;  // target_register_address
    localparam int ADDR_LSB = 9;
    localparam int RET_BIT  = 8;   // stack_return_select
    localparam int CHB_MSB  = 7;   // converter_b_channel_code
    localparam int CHB_LSB  = 4;
    localparam int CHA_MSB  = 3;   // converter_a_channel_code
    localparam int CHA_LSB  = 0;

    ////////////////////////////////////////////////////////////////////////////
    // bus
    localparam int         APB_ADDR_W = 8;        // covers byte address 0xf8
    localparam logic [1:0] STEP_LAST  = 2'h2;     // last local step index
    localparam logic [1:0] STEP_FIRST = 2'h0;     // first local step index

endpackage : seq_stack_pkg

// >>> pkg/seq_entry_if.sv
// Purpose: carrier between the bank top and one stack entry
// Assumes: single clock domain
// Notes:   the top drives write requests, the entry returns its stored word
`timescale 1ns/1ps
`default_nettype none
interface seq_entry_if;
    logic        wr_en;    // qualified apb write to this entry, one cycle
    logic [15:0] wr_data;  // low half of pwdata
    logic [15:0] word;     // stored entry word

    modport entry (input wr_en, input wr_data, output word);
    modport bank  (output wr_en, output wr_data, input word);
endinterface : seq_entry_if
`default_nettype wire

// >>> core/seq_stack_entry.sv
// Purpose: one sequencer stack entry word with frame checking
// Assumes: wr_en already qualified by the bank's address decode
// Notes:   a write lands only as a write frame carrying this entry's address
`timescale 1ns/1ps
`default_nettype none
module seq_stack_entry
    import seq_stack_pkg::*;
#(
    parameter logic [5:0]  OWN_INDEX  = IDX_ENTRY_28,  // own register address
    parameter logic [15:0] RESET_WORD = RST_ENTRY_28   // word after reset
)(
    input  wire logic   i_clock,  // system clock
    input  wire logic   i_rst,    // synchronous reset, high
    input  wire logic   i_ce,     // clock enable, freezes state when low
    seq_entry_if.entry  port_if   // request in, word out
);

    ////////////////////////////////////////////////////////////////////////////
    // frame qualification
    logic frame_ok;  // write frame addressed to this entry

    // a read frame or a frame naming another register must not alter the word
    assign frame_ok = port_if.wr_data[DIR_BIT]                         // RULE1
                    && (port_if.wr_data[ADDR_MSB:ADDR_LSB] == OWN_INDEX); // RULE2

    ////////////////////////////////////////////////////////////////////////////
    // storage: address field is pinned to own address so it always reads back
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            port_if.word <= RESET_WORD;  // RULE6
        end
        else if (i_ce && port_if.wr_en && frame_ok)
        begin
            // channel codes kept opaque, decoded by the base channel table
            port_if.word <= {port_if.wr_data[DIR_BIT], OWN_INDEX,
                             port_if.wr_data[RET_BIT:0]};  // RULE7
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    chk_own_address: assert property (@(posedge i_clock) disable iff (i_rst) // RULE2
        port_if.word[ADDR_MSB:ADDR_LSB] == OWN_INDEX)
        else $error("entry address field differs from own address");

    chk_foreign_ignored: assert property (@(posedge i_clock) disable iff (i_rst) // RULE2
        port_if.wr_en && (port_if.wr_data[ADDR_MSB:ADDR_LSB] != OWN_INDEX)
        |=> $stable(port_if.word))
        else $error("frame for another register changed the entry");

    chk_read_frame: assert property (@(posedge i_clock) disable iff (i_rst) // RULE1
        port_if.wr_en && !port_if.wr_data[DIR_BIT] |=> $stable(port_if.word))
        else $error("read frame changed the entry");

    chk_write_lands: assert property (@(posedge i_clock) disable iff (i_rst) // RULE1
        i_ce && port_if.wr_en && frame_ok
        |=> port_if.word[RET_BIT:0] == $past(port_if.wr_data[RET_BIT:0])
            && port_if.word[DIR_BIT])
        else $error("accepted write frame not stored");

endmodule : seq_stack_entry
`default_nettype wire

// >>> core/sequencer_stack_entries.sv
// Purpose: APB bank of sequencer stack entries 28 to 30 and their step pointer
// Assumes: I_CONV_DONE comes from logic on I_CLOCK, one-cycle pulse
// Notes:   channel outputs lag the step pointer by one cycle
//
// Function
// RULE1: bit 15 chooses read or write frame
// RULE2: bits 14..9 hold own address; selects entry
// RULE3: bit 8 set returns to first entry
// RULE4: bits 7..4 give converter B channel
// RULE5: bits 3..0 give converter A channel
// RULE6: reset words 0x7800, 0x7a00, 0x7c00
// RULE7: channel codes stored and applied opaquely
`timescale 1ns/1ps
`default_nettype none
module sequencer_stack_entries
    import seq_stack_pkg::*;
(
    input  wire logic                  I_CLOCK,       // 200 MHz system clock
    input  wire logic                  I_RST,         // synchronous reset, high
    input  wire logic                  I_CE,          // clock enable
    input  wire logic                  I_PSEL,        // apb select
    input  wire logic                  I_PENABLE,     // apb access phase
    input  wire logic                  I_PWRITE,      // apb direction
    input  wire logic [APB_ADDR_W-1:0] I_PADDR,       // apb byte address
    input  wire logic [31:0]           I_PWDATA,      // apb write data
    output logic      [31:0]           O_PRDATA,      // apb read data
    output logic                       O_PREADY,      // apb ready
    output logic                       O_PSLVERR,     // unmapped or misaligned
    input  wire logic                  I_CONV_DONE,   // ongoing conversion done
    output logic      [3:0]            O_CHAN_A,      // converter a channel code
    output logic      [3:0]            O_CHAN_B,      // converter b channel code
    output logic                       O_RETURN_FIRST,// current step returns
    output logic      [1:0]            O_STEP         // current local step
);

    ////////////////////////////////////////////////////////////////////////////
    // entries
    localparam logic [5:0]  ENTRY_IDX [ENTRY_COUNT] = '{IDX_ENTRY_28, IDX_ENTRY_29,
                                                       IDX_ENTRY_30};
    localparam logic [15:0] ENTRY_RST [ENTRY_COUNT] = '{RST_ENTRY_28, RST_ENTRY_29,
                                                       RST_ENTRY_30};

    seq_entry_if  ent_if [ENTRY_COUNT] ();  // one carrier per entry
    logic [15:0]  word   [ENTRY_COUNT];     // stored words, by step index
    logic [2:0]   hit;                      // address decode per entry
    logic         mapped;                   // any entry hit, aligned
    logic         xfer;                     // access completing this edge
    logic [1:0]   step;                     // local step pointer
    logic [1:0]   next_step;                // pointer after a conversion
    logic [15:0]  cur;                      // word of the current step
    logic [15:0]  sel_word;                 // word picked by the decoder

    assign xfer = I_PSEL && I_PENABLE && O_PREADY;

    generate
        for (genvar g = 0; g < ENTRY_COUNT; g++)
        begin : g_entry
            // byte address is four times the register index
            assign hit[g] = (I_PADDR[1:0] == 2'h0)
                          && (I_PADDR[APB_ADDR_W-1:2] == ENTRY_IDX[g]);
            assign ent_if[g].wr_en   = xfer && I_PWRITE && hit[g];
            assign ent_if[g].wr_data = I_PWDATA[15:0];
            assign word[g]           = ent_if[g].word;

            seq_stack_entry #(
                .OWN_INDEX  (ENTRY_IDX[g]),
                .RESET_WORD (ENTRY_RST[g])
            ) u_entry (
                .i_clock (I_CLOCK),
                .i_rst   (I_RST),
                .i_ce    (I_CE),
                .port_if (ent_if[g])
            );
        end
    endgenerate

    assign mapped = |hit;

    ////////////////////////////////////////////////////////////////////////////
    // read mux
    always_comb
    begin
        sel_word = 16'h0000;
        for (int k = 0; k < ENTRY_COUNT; k++)
        begin
            if (hit[k])
            begin
                sel_word = word[k];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb answer: ready and data are registered, so the first access cycle
    // completes; a frozen enable in setup simply adds wait states
    always_ff @(posedge I_CLOCK)
    begin
        if (I_RST)
        begin
            O_PREADY  <= 1'b0;
            O_PRDATA  <= 32'h0000_0000;
            O_PSLVERR <= 1'b0;
        end
        else if (I_CE)
        begin
            O_PREADY <= I_PSEL && !O_PREADY;
            if (I_PSEL && !O_PREADY)
            begin
                // bits above the word read as zero; unmapped reads zero
                O_PRDATA  <= {16'h0000, sel_word};
                O_PSLVERR <= !mapped;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // step pointer: wraps after the last local entry since later entries
    // live outside this bank
    assign cur = word[step];

    always_comb
    begin
        next_step = step;
        if (I_CONV_DONE)
        begin
            if (cur[RET_BIT])
            begin
                next_step = STEP_FIRST;  // RULE3
            end
            else if (step == STEP_LAST)
            begin
                next_step = STEP_FIRST;
            end
            else
            begin
                next_step = step + 2'h1;  // RULE3
            end
        end
    end

    always_ff @(posedge I_CLOCK)
    begin
        if (I_RST)
        begin
            step <= STEP_FIRST;
        end
        else if (I_CE)
        begin
            step <= next_step;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // step outputs, codes passed through untranslated
    always_ff @(posedge I_CLOCK)
    begin
        if (I_RST)
        begin
            O_CHAN_A       <= 4'h0;
            O_CHAN_B       <= 4'h0;
            O_RETURN_FIRST <= 1'b0;
            O_STEP         <= 2'h0;
        end
        else if (I_CE)
        begin
            O_CHAN_A       <= cur[CHA_MSB:CHA_LSB];  // RULE5 RULE7
            O_CHAN_B       <= cur[CHB_MSB:CHB_LSB];  // RULE4 RULE7
            O_RETURN_FIRST <= cur[RET_BIT];
            O_STEP         <= step;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    chk_return_first: assert property (@(posedge I_CLOCK) disable iff (I_RST) // RULE3
        I_CE && I_CONV_DONE && cur[RET_BIT] |=> step == STEP_FIRST)
        else $error("return flag did not send pointer to first entry");

    chk_advance_next: assert property (@(posedge I_CLOCK) disable iff (I_RST) // RULE3
        I_CE && I_CONV_DONE && !cur[RET_BIT] && step != STEP_LAST
        |=> step == $past(step) + 2'h1)
        else $error("pointer did not advance to next entry");

    chk_hold_step: assert property (@(posedge I_CLOCK) disable iff (I_RST) // RULE3
        !I_CONV_DONE |=> $stable(step))
        else $error("pointer moved without a conversion");

    chk_chan_b: assert property (@(posedge I_CLOCK) disable iff (I_RST) // RULE4
        I_CE |=> O_CHAN_B == $past(cur[CHB_MSB:CHB_LSB]) && O_STEP == $past(step))
        else $error("converter b code does not follow step entry");

    // outputs are registered from the current word, so compare with its value one edge back
    chk_chan_a: assert property (@(posedge I_CLOCK) disable iff (I_RST) // RULE5
        I_CE |=> O_CHAN_A == $past(cur[CHA_MSB:CHA_LSB])
                 && O_RETURN_FIRST == $past(cur[RET_BIT]))
        else $error("converter a code does not follow step entry");

    chk_reset_words: assert property (@(posedge I_CLOCK) // RULE6
        I_RST |=> word[0] == RST_ENTRY_28 && word[1] == RST_ENTRY_29
                  && word[2] == RST_ENTRY_30)
        else $error("entry reset word wrong");

    chk_apb_ready: assert property (@(posedge I_CLOCK) disable iff (I_RST)
        I_CE && I_PSEL && !I_PENABLE && !O_PREADY |=> O_PREADY)
        else $error("apb ready missing in first access cycle");

endmodule : sequencer_stack_entries
`default_nettype wire

// >>> sim/apb_host_model.sv
// Purpose: apb host that programs the sequencer stack entries
// Assumes: one clock; the slave answers with pready after any number of cycles
// Notes:   signals change by non-blocking assignment just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module apb_host_model
    import seq_stack_pkg::*;
(
    input  wire logic                  i_clock,   // bus clock
    input  wire logic [31:0]           i_prdata,  // read data
    input  wire logic                  i_pready,  // slave answer
    input  wire logic                  i_pslverr, // slave refusal
    output logic                       o_psel,    // select
    output logic                       o_penable, // access phase
    output logic                       o_pwrite,  // direction
    output logic      [APB_ADDR_W-1:0] o_paddr,   // byte address
    output logic      [31:0]           o_pwdata   // entry word in low half
);
    ////////////////////////////////////////////////////////////////////////////
    // idle bus from time zero, so nothing is requested during reset
    initial
    begin
        o_psel    = 1'b0;
        o_penable = 1'b0;
        o_pwrite  = 1'b0;
        o_paddr   = '0;
        o_pwdata  = '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one transfer; the caller builds the frame word, direction bit and address
    task automatic xfer(input logic wr, input logic [APB_ADDR_W-1:0] addr,
                        input logic [31:0] wdata, output logic [31:0] rdata,
                        output logic err);
        @(posedge i_clock);
        o_psel    <= 1'b1;
        o_penable <= 1'b0;
        o_pwrite  <= wr;
        o_paddr   <= addr;
        o_pwdata  <= wdata;
        @(posedge i_clock);
        o_penable <= 1'b1;
        // request held until pready is seen high; only then released
        do
            @(posedge i_clock);
        while (i_pready !== 1'b1);
        rdata     = i_prdata;
        err       = i_pslverr;
        o_psel    <= 1'b0;
        o_penable <= 1'b0;
    endtask : xfer
endmodule : apb_host_model
`default_nettype wire

// >>> sim/sequencer_stack_entries_bench.sv
// Purpose: self-checking bench for the sequencer stack entry bank
// Assumes: apb host model in its own file drives the register bus
// Notes:   table rows write then read back; stepping and reset by hand after
`timescale 1ns/1ps
`default_nettype none
module sequencer_stack_entries_bench
    import seq_stack_pkg::*;
;
    typedef struct packed {
        logic [7:0]  addr;  // byte address
        logic [15:0] wdata; // word written
        logic [15:0] word;  // word read back
        logic        err;   // refusal expected
    } row_s;
    logic                  clk = 1'b0;   // 200 MHz
    logic                  rst = 1'b1;   // held for 4 cycles
    logic                  ce = 1'b1;    // clock enable
    logic                  conv = 1'b0;  // conversion done pulse
    logic                  psel, penable, pwrite, pready, pslverr, ret;
    logic [APB_ADDR_W-1:0] paddr;
    logic [31:0]           pwdata, prdata, rd;
    logic [3:0]            chan_a, chan_b;
    logic [1:0]            step;
    logic                  er;
    int                    fails = 0, compares = 0, cycles = 0;
    row_s                  rows [7];

    always #2.5 clk = ~clk;

    sequencer_stack_entries u_sequencer_stack_entries (.I_CLOCK(clk), .I_RST(rst), .I_CE(ce),
        .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
        .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_CONV_DONE(conv), .O_CHAN_A(chan_a), .O_CHAN_B(chan_b), .O_RETURN_FIRST(ret),
        .O_STEP(step));
    apb_host_model u_apb_host_model (.i_clock(clk), .i_prdata(prdata), .i_pready(pready),
        .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
        .o_paddr(paddr), .o_pwdata(pwdata));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic results;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results

    // every entry reads its reset word, and the step state is cleared
    task automatic reset_words;
        logic [15:0] w [3];
        w = '{RST_ENTRY_28, RST_ENTRY_29, RST_ENTRY_30};
        check("step after reset", {21'h0, ret, chan_b, chan_a, step}, 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            u_apb_host_model.xfer(1'b0, 8'hf0 + 8'(4 * i), 32'h0, rd, er);
            check("reset word", rd, {16'h0, w[i]});
        end
    endtask : reset_words

    // one conversion-done pulse; outputs follow two edges after it is driven
    task automatic pulse(input logic [1:0] st, input logic [3:0] a, input logic [3:0] b,
                         input logic r);
        @(posedge clk);
        conv <= 1'b1;
        @(posedge clk);
        conv <= 1'b0;
        @(posedge clk);
        #1;
        check("step fields", {21'h0, ret, chan_b, chan_a, step}, {21'h0, r, b, a, st});
    endtask : pulse

    ////////////////////////////////////////////////////////////////////////////
    // hang guard: tests need under a hundred cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            results();
        end
    end

    initial
    begin
        // own write, read frame, foreign address, own address, unmapped, misaligned
        rows = '{'{8'hf0, 16'hf812, 16'hf812, 1'b0}, '{8'hf0, 16'h7834, 16'hf812, 1'b0},
                 '{8'hf4, 16'hf9ab, 16'h7a00, 1'b0}, '{8'hf4, 16'hfbab, 16'hfbab, 1'b0},
                 '{8'hf8, 16'hfd5f, 16'hfd5f, 1'b0}, '{8'hfc, 16'hfe00, 16'h0000, 1'b1},
                 '{8'hf1, 16'hf9ab, 16'h0000, 1'b1}};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        // look at the outputs once the edge has settled, not in its own time step
        #1;
        reset_words();
        foreach (rows[i])
        begin
            u_apb_host_model.xfer(1'b1, rows[i].addr, {16'h0, rows[i].wdata}, rd, er);
            check("write refusal", {31'h0, er}, {31'h0, rows[i].err});
            u_apb_host_model.xfer(1'b0, rows[i].addr, 32'h0, rd, er);
            check("read word", rd, {16'h0, rows[i].word});
            check("read refusal", {31'h0, er}, {31'h0, rows[i].err});
        end
        // a pulse while disabled leaves the step on entry 28
        @(posedge clk);
        ce <= 1'b0;
        pulse(2'h0, 4'h2, 4'h1, 1'b0);
        @(posedge clk);
        ce <= 1'b1;
        pulse(2'h1, 4'hb, 4'ha, 1'b1);
        pulse(2'h0, 4'h2, 4'h1, 1'b0);
        // clear the return flag of entry 29 so the sequence reaches entry 30
        u_apb_host_model.xfer(1'b1, 8'hf4, 32'h0000_fa34, rd, er);
        pulse(2'h1, 4'h4, 4'h3, 1'b0);
        pulse(2'h2, 4'hf, 4'h5, 1'b1);
        pulse(2'h0, 4'h2, 4'h1, 1'b0);
        // second reset in mid-run
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        reset_words();
        results();
    end
endmodule : sequencer_stack_entries_bench
`default_nettype wire
